// file: src/adc_conv_timer.sv
// Purpose: times one conversion in converter clock periods
// Assumes: start is a one-cycle pulse from the sequencer; abort stays high while power is off
// Notes:   hold freezes the count without losing progress
`timescale 1ns/1ns
module adc_conv_timer (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       tick,
   input  wire logic       start,
   input  wire logic       abort,
   input  wire logic       hold,
   input  wire logic       ten_bit,
   input  wire logic [1:0] sample_time,
   output logic            done
);

   typedef struct packed {
      logic [5:0] cnt;
      logic       busy;
      logic       done;
   } adc_tmr_state_t;

   adc_tmr_state_t s;
   adc_tmr_state_t next_s;
   logic [5:0]     total;

   always_comb begin
      next_s      = s;
      next_s.done = 1'b0;
      total       = adc_pkg::adc_total_clks(ten_bit, sample_time);
      if (abort) begin
         next_s.busy = 1'b0;
         next_s.cnt  = 6'h00;
      end else if (start) begin
         next_s.busy = 1'b1;
         next_s.cnt  = 6'h00;
      end else if (s.busy && tick && !hold) begin
         if (s.cnt == total - 6'h01) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end else begin
            next_s.cnt = s.cnt + 6'h01;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign done = s.done;

endmodule

// file: src/adc_ctrl.sv
// Purpose: converter control registers, sequencer and flag clearing
// Assumes: wait_mode, bdm_active and conv_result come from the same clock
// Notes:   zero-wait AHB-Lite slave; every response is OKAY
`timescale 1ns/1ns
module adc_ctrl (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        special_mode,
   input  wire logic        wait_mode,
   input  wire logic        bdm_active,
   input  wire logic [9:0]  conv_result,
   output logic             analog_power_on,
   output logic             converter_clk,
   output logic             seq_irq,
   output logic             conv_busy,
   output logic [3:0]       conv_channel
);

   // =====================================================
   // state
   typedef struct packed {
      logic [1:0]                 special_sync;
      logic                       a_valid;
      logic                       a_write;
      logic [7:0]                 a_addr;
      logic [31:0]                rdata;
      logic                       ready;
      logic [7:0]                 ctl_zero;
      logic                       power_on;
      logic                       fast_clear;
      logic                       stop_wait;
      logic                       irq_enable;
      logic                       irq_flag;
      logic [1:0]                 freeze;
      logic                       ten_bit;
      logic [1:0]                 sample_time;
      logic [4:0]                 prescale;
      logic                       eight_ch;
      logic                       scan;
      logic                       multi;
      logic [3:0]                 chan;
      adc_pkg::adc_seq_state_t    seq;
      logic [2:0]                 idx;
      logic                       seq_done;
      logic [7:0]                 ch_done;
      logic [7:0]                 armed;
      logic [7:0][9:0]            result;
      logic                       irq;
      logic                       busy;
      logic [3:0]                 channel;
   } adc_ctl_state_t;

   adc_ctl_state_t s;
   adc_ctl_state_t next_s;

   logic tick;
   logic conv_done;
   logic conv_start;
   logic conv_abort;
   logic conv_hold;

   // =====================================================
   // decoding
   function automatic logic is_result(input logic [7:0] a);
      return (a >= adc_pkg::OFF_RES_BASE) && (a <= adc_pkg::OFF_RES_LAST);
   endfunction

   function automatic logic [2:0] result_index(input logic [7:0] a);
      logic [7:0] d;
      d = a - adc_pkg::OFF_RES_BASE;
      return d[4:2];
   endfunction

   // =====================================================
   // next state
   always_comb begin
      logic       take;
      logic       wr;
      logic       abort;
      logic       restart;
      logic       halt_now;
      logic       no_issue;
      logic [2:0] ri;
      logic [2:0] last;
      logic [7:0] set_mask;
      logic [7:0] wb;
      logic [31:0] rd;
      take       = 1'b0;
      wr         = 1'b0;
      abort      = 1'b0;
      restart    = 1'b0;
      halt_now   = 1'b0;
      no_issue   = 1'b0;
      ri         = 3'h0;
      last       = 3'h0;
      set_mask   = 8'h00;
      wb         = 8'h00;
      rd         = 32'h0000_0000;
      conv_start = 1'b0;
      conv_abort = 1'b0;
      next_s     = s;

      next_s.special_sync = {s.special_sync[0], special_mode};
      next_s.ready        = 1'b1;

      // ---- data phase of a write
      wr = s.a_valid && s.a_write;
      wb = hwdata[7:0];
      if (wr) begin
         case (s.a_addr)
            adc_pkg::OFF_CTL_ZERO: begin
               next_s.ctl_zero = wb;
               abort           = 1'b1;
            end
            adc_pkg::OFF_CTL_RSVD: begin
               // reserved: no storage, no effect
               abort = 1'b0;
            end
            adc_pkg::OFF_CTL_POWER: begin
               next_s.power_on   = wb[adc_pkg::POWER_ON_BIT];
               next_s.fast_clear = wb[adc_pkg::FAST_CLEAR_BIT];
               next_s.stop_wait  = wb[adc_pkg::STOP_WAIT_BIT];
               next_s.irq_enable = wb[adc_pkg::IRQ_ENABLE_BIT];
               // flag bit is read-only, write data dropped
               abort = 1'b1;
            end
            adc_pkg::OFF_CTL_FRZ: begin
               next_s.freeze = wb[1:0];
               abort         = 1'b1;
            end
            adc_pkg::OFF_CTL_TIME: begin
               next_s.ten_bit     = wb[adc_pkg::TEN_BIT_BIT];
               next_s.sample_time = wb[adc_pkg::SAMPLE_LSB +: 2];
               next_s.prescale    = wb[adc_pkg::PRESCALE_LSB +: 5];
               abort              = 1'b1;
            end
            adc_pkg::OFF_SEQ_START: begin
               next_s.eight_ch = wb[adc_pkg::EIGHT_CH_BIT];
               next_s.scan     = wb[adc_pkg::SCAN_BIT];
               next_s.multi    = wb[adc_pkg::MULTI_BIT];
               next_s.chan     = wb[3:0];
               restart         = 1'b1;
            end
            default: begin
               abort = 1'b0;
            end
         endcase
      end

      // ---- sequencer control
      if (!next_s.power_on) begin
         abort = 1'b1;
      end
      if (abort || restart) begin
         // aborted sequences stay idle until the next start write
         next_s.seq  = adc_pkg::ADC_IDLE;
         conv_abort  = 1'b1;
         next_s.idx  = 3'h0;
      end
      if (restart) begin
         next_s.seq_done = 1'b0;
         next_s.irq_flag = 1'b0;
         next_s.ch_done  = 8'h00;
         next_s.armed    = 8'h00;
         if (next_s.power_on) begin
            next_s.seq = adc_pkg::ADC_ISSUE;
         end
      end

      halt_now = (s.stop_wait && wait_mode)
               || (bdm_active && s.freeze == adc_pkg::FRZ_NOW);
      no_issue = halt_now || (bdm_active && s.freeze == adc_pkg::FRZ_FINISH);
      conv_hold = halt_now;
      last      = s.eight_ch ? 3'h7 : 3'h3;

      if (!abort && !restart) begin
         case (s.seq)
            adc_pkg::ADC_ISSUE: begin
               if (!no_issue) begin
                  conv_start     = 1'b1;
                  next_s.seq     = adc_pkg::ADC_CONVERT;
                  next_s.channel = !s.multi ? s.chan
                                 : s.eight_ch ? {s.chan[3], s.idx}
                                 : {s.chan[3:2], s.idx[1:0]};
               end
            end
            adc_pkg::ADC_CONVERT: begin
               if (conv_done) begin
                  next_s.result[s.idx] = s.ten_bit ? conv_result
                                       : {2'h0, conv_result[9:2]};
                  set_mask[s.idx]      = 1'b1;
                  next_s.idx           = (s.idx == last) ? 3'h0 : s.idx + 3'h1;
                  if (s.idx == last) begin
                     next_s.seq_done = 1'b1;
                     next_s.irq_flag = 1'b1;
                     next_s.seq      = s.scan ? adc_pkg::ADC_ISSUE : adc_pkg::ADC_IDLE;
                  end else begin
                     next_s.seq = adc_pkg::ADC_ISSUE;
                  end
               end
            end
            default: begin
               next_s.seq = adc_pkg::ADC_IDLE;
            end
         endcase
      end

      // ---- address phase: read data and read side effects
      take = hsel && htrans[1] && hready;
      next_s.a_valid = take;
      next_s.a_write = take && hwrite;
      next_s.a_addr  = haddr[7:0];
      if (take && !hwrite) begin
         case (haddr[7:0])
            adc_pkg::OFF_CTL_ZERO:  rd[7:0] = next_s.ctl_zero;
            adc_pkg::OFF_CTL_RSVD:  rd[7:0] = 8'h00;
            adc_pkg::OFF_CTL_POWER: begin
               rd[adc_pkg::POWER_ON_BIT]   = next_s.power_on;
               rd[adc_pkg::FAST_CLEAR_BIT] = next_s.fast_clear;
               rd[adc_pkg::STOP_WAIT_BIT]  = next_s.stop_wait;
               rd[adc_pkg::IRQ_ENABLE_BIT] = next_s.irq_enable;
               rd[adc_pkg::IRQ_FLAG_BIT]   = next_s.irq_flag;
            end
            adc_pkg::OFF_CTL_FRZ:   rd[1:0] = next_s.freeze;
            adc_pkg::OFF_CTL_TIME: begin
               rd[adc_pkg::TEN_BIT_BIT]           = next_s.ten_bit;
               rd[adc_pkg::SAMPLE_LSB +: 2]       = next_s.sample_time;
               rd[adc_pkg::PRESCALE_LSB +: 5]     = next_s.prescale;
            end
            adc_pkg::OFF_SEQ_START: begin
               rd[adc_pkg::EIGHT_CH_BIT] = next_s.eight_ch;
               rd[adc_pkg::SCAN_BIT]     = next_s.scan;
               rd[adc_pkg::MULTI_BIT]    = next_s.multi;
               rd[3:0]                   = next_s.chan;
            end
            adc_pkg::OFF_STATUS: begin
               rd[adc_pkg::STAT_SEQ_BIT]      = next_s.seq_done;
               rd[adc_pkg::STAT_CNT_LSB +: 3] = next_s.idx;
               rd[7:0]                        = next_s.ch_done;
               // status read qualifies later result reads of the channels then done
               next_s.armed = next_s.ch_done;
            end
            default: begin
               if (is_result(haddr[7:0])) begin
                  ri      = result_index(haddr[7:0]);
                  rd[9:0] = next_s.result[ri];
               end
            end
         endcase
      end
      // any result access, read or write, counts for fast clear
      if (take && is_result(haddr[7:0])) begin
         ri = result_index(haddr[7:0]);
         if (s.fast_clear) begin
            next_s.ch_done[ri] = 1'b0;
            next_s.seq_done    = 1'b0;
            next_s.irq_flag    = 1'b0;
         end else if (!hwrite && next_s.armed[ri]) begin
            next_s.ch_done[ri] = 1'b0;
            next_s.armed[ri]   = 1'b0;
         end
      end
      // a completion in the clearing cycle wins
      next_s.ch_done = next_s.ch_done | set_mask;
      if (set_mask != 8'h00 && s.idx == last) begin
         next_s.seq_done = 1'b1;
         next_s.irq_flag = 1'b1;
      end
      next_s.rdata = rd;

      next_s.irq  = next_s.irq_enable && next_s.irq_flag;
      next_s.busy = (next_s.seq != adc_pkg::ADC_IDLE);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s             <= '0;
         s.ctl_zero    <= adc_pkg::RST_CTL_ZERO;
         s.power_on    <= adc_pkg::RST_CTL_POWER[adc_pkg::POWER_ON_BIT];
         s.fast_clear  <= adc_pkg::RST_CTL_POWER[adc_pkg::FAST_CLEAR_BIT];
         s.stop_wait   <= adc_pkg::RST_CTL_POWER[adc_pkg::STOP_WAIT_BIT];
         s.irq_enable  <= adc_pkg::RST_CTL_POWER[adc_pkg::IRQ_ENABLE_BIT];
         s.freeze      <= adc_pkg::RST_FREEZE;
         s.ten_bit     <= adc_pkg::RST_CTL_TIME[adc_pkg::TEN_BIT_BIT];
         s.sample_time <= adc_pkg::RST_CTL_TIME[adc_pkg::SAMPLE_LSB +: 2];
         s.prescale    <= adc_pkg::RST_CTL_TIME[adc_pkg::PRESCALE_LSB +: 5];
         s.seq         <= adc_pkg::ADC_IDLE;
         s.ready       <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // =====================================================
   // converter clock and conversion timing
   adc_prescaler u_prescaler (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .enable   (s.power_on),
      .prescale (s.prescale),
      .conv_clk (converter_clk),
      .tick     (tick)
   );

   adc_conv_timer u_timer (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .tick        (tick),
      .start       (conv_start),
      .abort       (conv_abort),
      .hold        (conv_hold),
      .ten_bit     (s.ten_bit),
      .sample_time (s.sample_time),
      .done        (conv_done)
   );

   // =====================================================
   // outputs
   assign hreadyout       = s.ready;
   assign hresp           = 1'b0;
   assign hrdata          = s.rdata;
   assign analog_power_on = s.power_on;
   assign seq_irq         = s.irq;
   assign conv_busy       = s.busy;
   assign conv_channel    = s.channel;

endmodule

// file: src/adc_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes:   register contents sit in the low bits, upper bits read zero
//
// Contract
// - control zero write aborts running sequence
// - reserved register: special-mode read, writes ignored; reads zero in every mode here
// - power/irq control write aborts running sequence
// - freeze control write aborts, suspends at breakpoint
// - timing write aborts; halt until sequence start
// - power off gates clock, aborts sequence
// - normal clear: status read, then result read
// - fast clear: result access clears its flag
// - stop-in-wait halts converter in wait mode
// - interrupt enable gates sequence-done interrupt
// - interrupt flag set on completion, not writable
// - freeze codes: run, reserved, finish, freeze now
// - ten-bit select picks 8 or 10 bits
// - sample codes give 2, 4, 8, 16 clocks
// - total 18/20/24/32 or 20/22/26/34 clocks
// - prescaler divides by value plus one, then two
// - prescale zero acts as one; reset divides four
// - sequence start write restarts, clears done flags
// - channel done flag sets per result, sticks
// - sequence done clears per selected clearing scheme; here only a fast-clear result access or a start write clears it
package adc_pkg;

   // =====================================================
   // register offsets (byte addresses)
   localparam logic [7:0] OFF_CTL_ZERO  = 8'h00;
   localparam logic [7:0] OFF_CTL_RSVD  = 8'h04;
   localparam logic [7:0] OFF_CTL_POWER = 8'h08;
   localparam logic [7:0] OFF_CTL_FRZ   = 8'h0c;
   localparam logic [7:0] OFF_CTL_TIME  = 8'h10;
   localparam logic [7:0] OFF_SEQ_START = 8'h14;
   localparam logic [7:0] OFF_STATUS    = 8'h18;
   localparam logic [7:0] OFF_RES_BASE  = 8'h20;
   localparam logic [7:0] OFF_RES_LAST  = 8'h3c;

   // =====================================================
   // field positions
   localparam int POWER_ON_BIT   = 7;
   localparam int FAST_CLEAR_BIT = 6;
   localparam int STOP_WAIT_BIT  = 5;
   localparam int IRQ_ENABLE_BIT = 1;
   localparam int IRQ_FLAG_BIT   = 0;
   localparam int TEN_BIT_BIT    = 7;
   localparam int SAMPLE_LSB     = 5;
   localparam int PRESCALE_LSB   = 0;
   localparam int EIGHT_CH_BIT   = 6;
   localparam int SCAN_BIT       = 5;
   localparam int MULTI_BIT      = 4;
   localparam int STAT_SEQ_BIT   = 15;
   localparam int STAT_CNT_LSB   = 8;

   // =====================================================
   // reset values
   localparam logic [7:0] RST_CTL_ZERO  = 8'h00;
   localparam logic [7:0] RST_CTL_POWER = 8'h00;
   localparam logic [1:0] RST_FREEZE    = 2'h0;
   localparam logic [7:0] RST_CTL_TIME  = 8'h01;

   // =====================================================
   // freeze codes
   localparam logic [1:0] FRZ_RUN    = 2'h0;
   localparam logic [1:0] FRZ_RSVD   = 2'h1;
   localparam logic [1:0] FRZ_FINISH = 2'h2;
   localparam logic [1:0] FRZ_NOW    = 2'h3;

   // =====================================================
   // timing counts, in converter clock periods
   localparam logic [5:0] SAMPLE_CLKS_0 = 6'h02;
   localparam logic [5:0] SAMPLE_CLKS_1 = 6'h04;
   localparam logic [5:0] SAMPLE_CLKS_2 = 6'h08;
   localparam logic [5:0] SAMPLE_CLKS_3 = 6'h10;
   localparam logic [5:0] BASE_CLKS_8   = 6'h10;
   localparam logic [5:0] BASE_CLKS_10  = 6'h12;
   localparam logic [4:0] PRESCALE_MIN  = 5'h01;

   typedef enum logic [1:0] {
      ADC_IDLE,
      ADC_ISSUE,
      ADC_CONVERT
   } adc_seq_state_t;

   function automatic logic [5:0] adc_total_clks(input logic ten, input logic [1:0] smp);
      logic [5:0] s;
      case (smp)
         2'h0:    s = SAMPLE_CLKS_0;
         2'h1:    s = SAMPLE_CLKS_1;
         2'h2:    s = SAMPLE_CLKS_2;
         default: s = SAMPLE_CLKS_3;
      endcase
      return s + (ten ? BASE_CLKS_10 : BASE_CLKS_8);
   endfunction

endpackage

// file: src/adc_prescaler.sv
// Purpose: modulo prescaler plus divide-by-two for the converter clock
// Assumes: prescale value may change at any time; new value takes effect at once
// Notes:   tick pulses one cycle at each rising converter clock edge
`timescale 1ns/1ns
module adc_prescaler (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       enable,
   input  wire logic [4:0] prescale,
   output logic            conv_clk,
   output logic            tick
);

   typedef struct packed {
      logic [4:0] cnt;
      logic       clk_q;
      logic       tick;
   } adc_psc_state_t;

   adc_psc_state_t s;
   adc_psc_state_t next_s;
   logic [4:0]     divisor;

   always_comb begin
      next_s      = s;
      next_s.tick = 1'b0;
      divisor     = (prescale == 5'h00) ? adc_pkg::PRESCALE_MIN : prescale;
      if (!enable) begin
         // gated: clock held low while powered down
         next_s.cnt   = 5'h00;
         next_s.clk_q = 1'b0;
      end else if (s.cnt >= divisor) begin
         // divisor+1 cycles per half period keeps the output symmetric
         next_s.cnt   = 5'h00;
         next_s.clk_q = ~s.clk_q;
         next_s.tick  = ~s.clk_q;
      end else begin
         next_s.cnt = s.cnt + 5'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign conv_clk = s.clk_q;
   assign tick     = s.tick;

endmodule

// file: tb/adc_ctrl_assertions.sv
// Purpose: port-level properties of the converter control block
// Assumes: one clock domain, single-word register transfers
// Notes:   bound to adc_ctrl from the bench top file
`timescale 1ns/1ns
module adc_ctrl_assertions (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        analog_power_on,
   input wire logic        converter_clk,
   input wire logic        seq_irq,
   input wire logic        conv_busy
);
   // =====================================================
   // helpers
   wire       tk = hsel && htrans[1] && hready;
   wire [7:0] a  = haddr[7:0];
   wire       ctl_wr = tk && hwrite && (a == 8'h00 || a == 8'h08 || a == 8'h0c || a == 8'h10);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // start ignored while powered off, so power is checked after the take
   sequence s_start;
      tk && hwrite && a == 8'h14 ##1 analog_power_on;
   endsequence
   // =====================================================
   // properties
   property p_abort;
      ctl_wr |-> ##[1:3] !conv_busy;
   endproperty
   property p_res_read;
      tk && !hwrite && a == 8'h04 |=> hrdata == 32'h0;
   endproperty
   property p_off_idle;
      $fell(analog_power_on) |-> ##[0:2] !conv_busy;
   endproperty
   property p_off_clk;
      !analog_power_on && !$past(analog_power_on) |-> !converter_clk;
   endproperty
   property p_clk_min;
      $rose(converter_clk) && analog_power_on |=> converter_clk;
   endproperty
   property p_clk_max;
      $rose(converter_clk) |-> ##[1:32] !converter_clk;
   endproperty
   property p_start_busy;
      s_start |-> ##[0:2] conv_busy;
   endproperty
   property p_start_clear;
      s_start |-> ##[0:2] !seq_irq;
   endproperty
   a_abort: assert property (p_abort) else $error("control write left converter busy");
   a_res_read: assert property (p_res_read) else $error("reserved register read nonzero");
   a_off_idle: assert property (p_off_idle) else $error("power off did not stop sequence");
   a_off_clk: assert property (p_off_clk) else $error("converter clock runs while off");
   a_clk_min: assert property (p_clk_min) else $error("converter clock high too short");
   a_clk_max: assert property (p_clk_max) else $error("converter clock high too long");
   a_start_busy: assert property (p_start_busy) else $error("start did not begin sequence");
   a_start_clear: assert property (p_start_clear) else $error("start did not clear irq");
   c_abort: cover property (ctl_wr ##1 conv_busy);
   c_irq: cover property ($rose(seq_irq));
   c_off: cover property ($fell(analog_power_on));
endmodule

// file: tb/adc_tb.sv
// Purpose: self-checking bench for the converter control block
// Assumes: zero-wait slave, reset prescale gives a 4-cycle converter clock
// Notes:   expectations come from a small register model in the bench
`timescale 1ns/1ns
`define CHK(nm, ex, sn) begin n_compared++; if ((sn) !== (ex)) begin n_errors++; \
   $display("unexpected %s: expected %h, seen %h", nm, ex, sn); end end
module tb;
   // =====================================================
   // signals and model
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        spm = 1'b0;
   logic        wt = 1'b0;
   logic        background_debug_state = 1'b0;
   logic [9:0]  res = 10'h0;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        pwr;
   logic        cclk;
   logic        irq;
   logic        busy;
   logic [3:0]  chan;
   logic [31:0] rst[5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
   logic [31:0] wm[5] = '{32'hff, 32'h0, 32'he2, 32'h3, 32'hff};
   logic [31:0] ps[4] = '{32'h0, 32'h1, 32'h3, 32'h7};
   logic [7:0]  ab[4] = '{8'h00, 8'h08, 8'h0c, 8'h10};
   logic [31:0] ad[4] = '{32'h0, 32'h80, 32'h0, 32'h1};
   logic [5:0]  fz[5] = '{6'h35, 6'h04, 6'h25, 6'h0b, 6'h02};
   logic [5:0]  f;
   logic [31:0] v;
   int          d;
   int          tot;
   int          cyc = 0;
   int          n_errors = 0;
   int          n_compared = 0;

   adc_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .special_mode(spm),
      .wait_mode(wt), .bdm_active(background_debug_state), .conv_result(res), .analog_power_on(pwr),
      .converter_clk(cclk), .seq_irq(irq), .conv_busy(busy), .conv_channel(chan));

   // =====================================================
   // bus and wait tasks
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] r);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] r;
      xfer(a, 1'b1, wd, r);
   endtask
   task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] mk);
      logic [31:0] r;
      xfer(a, 1'b0, 32'h0, r);
      `CHK(nm, e, r & mk)
   endtask
   task automatic idle(output int n);
      n = 0;
      do begin @(posedge hclk); n++; end while (busy === 1'b1);
   endtask
   task automatic run(input logic [31:0] s);
      wr(8'h14, s);
      rc("start clear", 8'h18, 32'h0, 32'h80ff);
      idle(d);
   endtask
   task automatic halfp(output int n);
      n = 0;
      while (cclk !== 1'b0) @(posedge hclk);
      while (cclk !== 1'b1) @(posedge hclk);
      while (cclk === 1'b1) begin @(posedge hclk); n++; end
   endtask
   task automatic give_verdict;
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // =====================================================
   // clock, watchdog, sequence
   initial begin
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      void'($urandom(32'h3193dd40));
      foreach (rst[i]) rc("reset", 8'(i * 4), rst[i], 32'hff);
      repeat (4) begin
         for (int i = 0; i < 5; i++) begin
            v = $urandom & ((i == 4) ? 32'he7 : 32'hff);
            spm <= v[3];
            wr(8'(i * 4), v);
            rc("register", 8'(i * 4), v & wm[i], 32'hff);
         end
      end
      rc("unmapped", 8'h40, 32'h0, 32'hffffffff);
      wr(8'h08, 32'h80);
      foreach (ps[k]) begin
         wr(8'h10, ps[k]);
         halfp(d);
         `CHK("half period", (ps[k] == 32'h0) ? 2 : ps[k] + 1, d)
      end
      // the four sequence steps are not resolved, so duration gets a window
      for (int j = 0; j < 8; j++) begin
         tot = 16 + (2 << (j % 4)) + 2 * (j / 4);
         wr(8'h08, 32'h80 | 32'(j % 2) << 1);
         wr(8'h10, 32'(j / 4) << 7 | 32'(j % 4) << 5 | 32'h1);
         res <= 10'($urandom);
         run(32'h0);
         `CHK("duration", 1'b1, d >= 16 * tot - 4 && d <= 16 * tot + 24)
         v = (j >= 4) ? {22'h0, res} : {24'h0, res[9:2]};
         rc("irq flag", 8'h08, 32'h81 | 32'(j % 2) << 1, 32'hff);
         `CHK("irq", 1'(j % 2), irq)
         rc("result", 8'h24, v, 32'h3ff);
         rc("status", 8'h18, 32'h800f, 32'h80ff);
         for (int i = 0; i < 4; i++)
            rc("result", 8'(32 + 4 * i), v, 32'h3ff);
         rc("status", 8'h18, 32'h8000, 32'h80ff);
      end
      wr(8'h08, 32'hc2);
      run(32'h1d);
      rc("fast", 8'h24, v, 32'h3ff);
      rc("fast status", 8'h18, 32'h000d, 32'h80ff);
      `CHK("channel", 4'hf, chan)
      `CHK("irq cleared", 1'b0, irq)
      foreach (ab[k]) begin
         wr(8'h08, 32'h80);
         wr(8'h14, 32'h0);
         repeat (20) @(posedge hclk);
         wr(ab[k], ad[k]);
         repeat (200) @(posedge hclk);
         rc("halted", 8'h18, 32'h0, 32'hff);
         `CHK("busy", 1'b0, busy)
      end
      foreach (fz[k]) begin
         f = fz[k];
         wr(8'h0c, {30'h0, f[5:4]});
         wr(8'h08, 32'h80 | 32'(f[3]) << 5);
         wr(8'h14, 32'h0);
         background_debug_state <= f[2];
         wt <= f[1];
         repeat (400) @(posedge hclk);
         `CHK("held", f[0], busy)
         background_debug_state <= 1'b0;
         wt <= 1'b0;
         idle(d);
         rc("resumed", 8'h18, 32'h8000, 32'h8000);
      end
      wr(8'h08, 32'h0);
      wr(8'h14, 32'h0);
      rc("off", 8'h08, 32'h0, 32'hfe);
      `CHK("power", 1'b0, pwr)
      `CHK("clock gated", 1'b0, cclk)
      `CHK("idle off", 1'b0, busy)
      give_verdict();
   end
endmodule

bind adc_ctrl adc_ctrl_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .analog_power_on(analog_power_on), .converter_clk(converter_clk), .seq_irq(seq_irq),
   .conv_busy(conv_busy));
